/* rtl/fcdu_pkg.sv */
// Purpose: shared constants for the flash command and descriptor unit
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes:   command codes and offsets of command/status are local choices
package fcdu_pkg;
  localparam logic [7:0]  FCDU_CMD_OFS   = 8'h04;
  localparam logic [7:0]  FCDU_STAT_OFS  = 8'h08;
  localparam logic [7:0]  FCDU_RES_OFS   = 8'h0c;
  localparam int          FCDU_KEY_MSB   = 31;
  localparam int          FCDU_KEY_LSB   = 24;
  localparam int          FCDU_ARG_MSB   = 23;
  localparam int          FCDU_ARG_LSB   = 8;
  localparam int          FCDU_CODE_MSB  = 7;
  localparam int          FCDU_SB_READY  = 0;
  localparam int          FCDU_SB_CMDERR = 1;
  localparam int          FCDU_SB_LOCKERR = 2;
  localparam int          FCDU_DESC_HEAD = 4;
  localparam int          FCDU_WORD_BITS = 32;
  localparam logic [7:0]  FCDU_GET_DESCRIPTOR_CMD = 8'h00;
  localparam logic [7:0]  FCDU_WP   = 8'h01;
  localparam logic [7:0]  FCDU_EWP  = 8'h03;
  localparam logic [7:0]  FCDU_EA   = 8'h05;
  localparam logic [7:0]  FCDU_EPL  = 8'h06;
  localparam logic [7:0]  FCDU_ES   = 8'h07;
  localparam logic [7:0]  FCDU_EPA  = 8'h08;
  localparam logic [7:0]  FCDU_SLB  = 8'h09;
  localparam logic [7:0]  FCDU_CLB  = 8'h0a;
  localparam logic [7:0]  FCDU_GLB  = 8'h0b;
  localparam logic [7:0]  FCDU_SGP  = 8'h0c;
  localparam logic [7:0]  FCDU_CGP  = 8'h0d;
  localparam logic [7:0]  FCDU_GGP  = 8'h0e;
  localparam logic [7:0]  FCDU_GCAL = 8'h0f;
  typedef enum logic [2:0] {
    FCDU_OP_READ  = 3'h0,
    FCDU_OP_PROG  = 3'h1,
    FCDU_OP_EPAGE = 3'h2,
    FCDU_OP_ESECT = 3'h3,
    FCDU_OP_EPLAN = 3'h4,
    FCDU_OP_EALL  = 3'h5
  } fcdu_op_e;
  typedef enum logic [2:0] {
    FCDU_IDLE  = 3'b000,
    FCDU_ERASE = 3'b001,
    FCDU_PROG  = 3'b011,
    FCDU_FETCH = 3'b100
  } fcdu_state_e;
  typedef enum logic [1:0] {
    FCDU_RES_NONE = 2'h0,
    FCDU_RES_DESC = 2'h1,
    FCDU_RES_LOCK = 2'h2,
    FCDU_RES_VAL  = 2'h3
  } fcdu_res_e;
endpackage

/* rtl/fcdu_top.sv */
// Purpose: flash command sequencer, descriptor readout and wide fetch path
// Assumes: flash macro on CLK, answers each FL_START with one FL_DONE pulse
// Notes:   lock and nv bits are held in flops and reset to zero
// Contract
// - flash array joined to 32-bit bus through a 128- or 64-bit interface
// - wide fetch path with a line buffer for repeated code loops
// - 128 lock bits, each blocks write and erase of its region
// - commands accepted only with the correct keyword byte
// - erase whole flash, one plane, one sector or page groups
// - optional erase automatically before programming
// - lock and unlock commands touch one lock bit each
// - general-purpose nv bits and calibration readback
// - runs on the free clock, no gating changes behaviour; here CE low freezes all unit state but the reset sync
// - interrupt pulses only on ready rising
// - get-descriptor puts word 0 in result when ready rises
// - each result read advances to the next descriptor word
// - reads after the last word return zero until next command
// - plane sizes start at word 4, one per plane
// - lock count follows the plane sizes
// - lock region sizes follow the lock count
// - results wider than 32 bits stream out one word per read
`timescale 1ns/1ps
`default_nettype none
module fcdu_top
  import fcdu_pkg::*;
#(
  parameter int          FL_WIDTH    = 128,
  parameter int          ADDR_W      = 20,
  parameter int          NLOCK       = 128,
  parameter int          NPLANE      = 1,
  parameter int          NGPNVM      = 2,
  parameter int          FLASH_BYTES = 32'h0008_0000,
  parameter int          PAGE_BYTES  = 512,
  parameter logic [7:0]  CMD_KEY     = 8'h5a,
  parameter logic [31:0] IF_DESC     = 32'h0000_0001,
  parameter logic [31:0] CAL_WORD    = 32'h0000_0000
) (
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire logic                  CE,
  input  wire logic [7:0]            REG_ADDR,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  input  wire logic [31:0]           REG_WDATA,
  output logic      [31:0]           REG_RDATA,
  output logic                       FLASH_IRQ,
  output logic      [NGPNVM-1:0]     GP_BITS,
  input  wire logic                  FETCH_REQ,
  input  wire logic [ADDR_W-1:0]     FETCH_ADDR,
  output logic                       FETCH_VALID,
  output logic      [31:0]           FETCH_DATA,
  output logic                       FL_START,
  output fcdu_pkg::fcdu_op_e         FL_OP,
  output logic      [15:0]           FL_ADDR,
  input  wire logic                  FL_DONE,
  input  wire logic [FL_WIDTH-1:0]   FL_RDATA
);
  import fcdu_pkg::*;

  localparam int LSB      = $clog2(FL_WIDTH / 8);
  localparam int PAGES    = FLASH_BYTES / PAGE_BYTES;
  localparam int PPR      = PAGES / NLOCK;
  localparam int RPP      = NLOCK / NPLANE;
  localparam int DESC_LEN = FCDU_DESC_HEAD + NPLANE + 1 + NLOCK;
  localparam int LOCK_LEN = NLOCK / FCDU_WORD_BITS;

  typedef struct packed {
    fcdu_state_e               st;
    logic                      ready;
    logic                      irq;
    logic                      cmd_err;
    logic                      lock_err;
    logic [7:0]                cmd;
    logic [15:0]               arg;
    logic [NLOCK-1:0]          lock;
    logic [NGPNVM-1:0]         gp;
    fcdu_res_e                 res_kind;
    logic [8:0]                res_idx;
    logic [8:0]                res_len;
    logic [31:0]               res_val;
    logic [31:0]               rdata;
    logic                      fl_start;
    fcdu_op_e                  fl_op;
    logic [15:0]               fl_addr;
    logic                      fpend;
    logic [ADDR_W-1:0]         faddr;
    logic                      line_ok;
    logic [ADDR_W-LSB-1:0]     line_tag;
    logic [FL_WIDTH-1:0]       line;
    logic                      fvalid;
    logic [31:0]               fdata;
  } fcdu_state_s;

  fcdu_state_s s;
  fcdu_state_s n;
  logic [1:0]  rst_sync;
  logic        rst_n_int;
  logic        accept;
  logic        locked;
  logic [31:0] res_word;
  logic [7:0]  code;

  function automatic logic [31:0] desc_word(input int i);
    if (i == 0) begin
      return IF_DESC;
    end else if (i == 1) begin
      return 32'(FLASH_BYTES);
    end else if (i == 2) begin
      return 32'(PAGE_BYTES);
    end else if (i == 3) begin
      return 32'(NPLANE);
    end else if (i < FCDU_DESC_HEAD + NPLANE) begin
      return 32'(FLASH_BYTES / NPLANE);
    end else if (i == FCDU_DESC_HEAD + NPLANE) begin
      return 32'(NLOCK);
    end else begin
      return 32'(FLASH_BYTES / NLOCK);
    end
  endfunction

  // reset release through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync[1];

  always_comb begin
    n        = s;
    n.fl_start = 1'b0;
    n.fvalid = 1'b0;
    code     = REG_WDATA[FCDU_CODE_MSB:0];
    locked   = 1'b0;
    accept   = 1'b0;
    res_word = 32'h0;
    // result word at the current read index
    if (s.res_idx < s.res_len) begin
      unique case (s.res_kind)
        FCDU_RES_NONE: res_word = 32'h0;
        FCDU_RES_DESC: res_word = desc_word(int'(s.res_idx));
        FCDU_RES_LOCK: res_word = s.lock[s.res_idx*FCDU_WORD_BITS +: FCDU_WORD_BITS];
        FCDU_RES_VAL:  res_word = s.res_val;
      endcase
    end
    // register reads, result read advances the index
    if (REG_RD) begin
      unique case (REG_ADDR)
        FCDU_STAT_OFS: begin
          n.rdata = 32'h0;
          n.rdata[FCDU_SB_READY] = s.ready;
          n.rdata[FCDU_SB_CMDERR] = s.cmd_err;
          n.rdata[FCDU_SB_LOCKERR] = s.lock_err;
        end
        FCDU_RES_OFS: begin
          n.rdata = res_word;
          if (s.res_idx < s.res_len) begin
            n.res_idx = s.res_idx + 9'h1;
          end
        end
        default: n.rdata = 32'h0;
      endcase
    end
    // lock scope of the requested operation
    for (int i = 0; i < NLOCK; i++) begin
      if (s.lock[i] && (code == FCDU_EA || (code == FCDU_EPL && i / RPP == int'(REG_WDATA[FCDU_ARG_MSB:FCDU_ARG_LSB]))
          || ((code == FCDU_WP || code == FCDU_EWP || code == FCDU_ES || code == FCDU_EPA)
          && i == int'(REG_WDATA[FCDU_ARG_MSB:FCDU_ARG_LSB]) / PPR))) begin
        locked = 1'b1;
      end
    end
    // command write
    if (REG_WR && REG_ADDR == FCDU_CMD_OFS) begin
      if (REG_WDATA[FCDU_KEY_MSB:FCDU_KEY_LSB] != CMD_KEY || s.st != FCDU_IDLE || !s.ready) begin
        n.cmd_err = 1'b1;
      end else begin
        accept     = 1'b1;
        n.ready    = 1'b0;
        n.cmd_err  = 1'b0;
        n.lock_err = 1'b0;
        n.res_kind = FCDU_RES_NONE;
        n.res_idx  = 9'h0;
        n.res_len  = 9'h0;
        n.cmd      = code;
        n.arg      = REG_WDATA[FCDU_ARG_MSB:FCDU_ARG_LSB];
        unique case (code)
          FCDU_GET_DESCRIPTOR_CMD: begin
            n.res_kind = FCDU_RES_DESC;
            n.res_len  = 9'(DESC_LEN);
          end
          FCDU_WP, FCDU_EWP, FCDU_EA, FCDU_EPL, FCDU_ES, FCDU_EPA: begin
            if (locked) begin
              n.lock_err = 1'b1;
            end else begin
              n.fl_start = 1'b1;
              n.fl_addr  = REG_WDATA[FCDU_ARG_MSB:FCDU_ARG_LSB];
              n.line_ok  = 1'b0;
              n.st       = (code == FCDU_WP) ? FCDU_PROG : FCDU_ERASE;
              unique case (code)
                FCDU_WP:  n.fl_op = FCDU_OP_PROG;
                FCDU_EA:  n.fl_op = FCDU_OP_EALL;
                FCDU_EPL: n.fl_op = FCDU_OP_EPLAN;
                FCDU_ES:  n.fl_op = FCDU_OP_ESECT;
                default:  n.fl_op = FCDU_OP_EPAGE;
              endcase
            end
          end
          FCDU_SLB, FCDU_CLB: begin
            if (int'(n.arg) >= PAGES) begin
              n.cmd_err = 1'b1;
            end else begin
              n.lock[int'(n.arg) / PPR] = (code == FCDU_SLB);
            end
          end
          FCDU_GLB: begin
            n.res_kind = FCDU_RES_LOCK;
            n.res_len  = 9'(LOCK_LEN);
          end
          FCDU_SGP, FCDU_CGP: begin
            if (int'(n.arg) >= NGPNVM) begin
              n.cmd_err = 1'b1;
            end else begin
              n.gp[int'(n.arg)] = (code == FCDU_SGP);
            end
          end
          FCDU_GGP: begin
            n.res_kind = FCDU_RES_VAL;
            n.res_len  = 9'h1;
            n.res_val  = 32'(s.gp);
          end
          FCDU_GCAL: begin
            n.res_kind = FCDU_RES_VAL;
            n.res_len  = 9'h1;
            n.res_val  = CAL_WORD;
          end
          default: n.cmd_err = 1'b1;
        endcase
      end
    end
    // sequencer
    unique case (s.st)
      FCDU_IDLE: begin
        if (!s.ready) begin
          n.ready = 1'b1;
        end else if (s.fpend && !accept) begin
          n.fpend = 1'b0;
          if (s.line_ok && s.line_tag == s.faddr[ADDR_W-1:LSB]) begin
            n.fvalid = 1'b1;
            n.fdata  = s.line[s.faddr[LSB-1:2]*FCDU_WORD_BITS +: FCDU_WORD_BITS];
          end else begin
            n.st       = FCDU_FETCH;
            n.fl_start = 1'b1;
            n.fl_op    = FCDU_OP_READ;
            n.fl_addr  = 16'(s.faddr[ADDR_W-1:LSB]);
          end
        end
      end
      FCDU_ERASE: begin
        if (FL_DONE) begin
          if (s.cmd == FCDU_EWP) begin
            n.st       = FCDU_PROG;
            n.fl_start = 1'b1;
            n.fl_op    = FCDU_OP_PROG;
          end else begin
            n.st    = FCDU_IDLE;
            n.ready = 1'b1;
          end
        end
      end
      FCDU_PROG: begin
        if (FL_DONE) begin
          n.st    = FCDU_IDLE;
          n.ready = 1'b1;
        end
      end
      FCDU_FETCH: begin
        if (FL_DONE) begin
          n.st       = FCDU_IDLE;
          n.line     = FL_RDATA;
          n.line_ok  = 1'b1;
          n.line_tag = s.faddr[ADDR_W-1:LSB];
          n.fvalid   = 1'b1;
          n.fdata    = FL_RDATA[s.faddr[LSB-1:2]*FCDU_WORD_BITS +: FCDU_WORD_BITS];
        end
      end
      default: n.st = FCDU_IDLE;
    endcase
    if (FETCH_REQ) begin
      n.fpend = 1'b1;
      n.faddr = FETCH_ADDR;
    end
    n.irq = n.ready & ~s.ready;
  end

  // free-running clock, only the enable holds state
  always_ff @(posedge CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s <= '0;
    end else if (CE) begin
      s <= n;
    end
  end

  assign REG_RDATA   = s.rdata;
  assign FLASH_IRQ   = s.irq;
  assign GP_BITS     = s.gp;
  assign FETCH_VALID = s.fvalid;
  assign FETCH_DATA  = s.fdata;
  assign FL_START    = s.fl_start;
  assign FL_OP       = s.fl_op;
  assign FL_ADDR     = s.fl_addr;
endmodule
`default_nettype wire

/* bench/fcdu_chk_assertions.sv */
// Purpose: port checks for fcdu_top
// Assumes: CE held high
// Notes:   bound into every fcdu_top
`timescale 1ns/1ps
`default_nettype none
module fcdu_chk
  import fcdu_pkg::*;
#(
  parameter logic [7:0] CMD_KEY = 8'h5a
) (
  input wire logic               CLK,
  input wire logic               RST_N,
  input wire logic [7:0]         REG_ADDR,
  input wire logic               REG_WR,
  input wire logic               REG_RD,
  input wire logic [31:0]        REG_WDATA,
  input wire logic [31:0]        REG_RDATA,
  input wire logic               FLASH_IRQ,
  input wire logic               FETCH_VALID,
  input wire logic               FL_START,
  input wire fcdu_pkg::fcdu_op_e FL_OP,
  input wire logic [15:0]        FL_ADDR,
  input wire logic               FL_DONE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_cmd_get_descriptor_cmd;
    REG_WR && REG_ADDR == FCDU_CMD_OFS && REG_WDATA[31:24] == CMD_KEY
      && REG_WDATA[7:0] == FCDU_GET_DESCRIPTOR_CMD;
  endsequence
  sequence s_bad_key;
    REG_WR && REG_ADDR == FCDU_CMD_OFS && REG_WDATA[31:24] != CMD_KEY;
  endsequence
  a_irq_one_pulse: assert property (FLASH_IRQ |=> !FLASH_IRQ)
    else $error("irq wider than one cycle");
  a_get_descriptor_cmd_irq_time: assert property (s_cmd_get_descriptor_cmd |-> !FLASH_IRQ [*2] ##1 FLASH_IRQ)
    else $error("descriptor ready irq late or early");
  a_bad_key_quiet: assert property (s_bad_key |=> !FLASH_IRQ [*4])
    else $error("irq after command with bad key");
  a_prog_done_irq: assert property ((FL_DONE && FL_OP == FCDU_OP_PROG) |=> FLASH_IRQ)
    else $error("no irq one cycle after program done");
  a_read_done_fetch: assert property ((FL_DONE && FL_OP == FCDU_OP_READ) |=> FETCH_VALID)
    else $error("fetch not served after line read");
  a_fetch_one_pulse: assert property (FETCH_VALID |=> !FETCH_VALID)
    else $error("fetch valid wider than one cycle");
  a_result_holds: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  a_op_holds: assert property (!FL_START |-> $stable({FL_OP, FL_ADDR}))
    else $error("flash op changed without a start");
endmodule
bind fcdu_top fcdu_chk #(.CMD_KEY(CMD_KEY)) i_chk (.CLK(CLK), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .FLASH_IRQ(FLASH_IRQ), .FETCH_VALID(FETCH_VALID),
  .FL_START(FL_START), .FL_OP(FL_OP), .FL_ADDR(FL_ADDR), .FL_DONE(FL_DONE));
`default_nettype wire

/* bench/fcdu_flash_model.sv */
// Purpose: behavioural flash macro
// Assumes: one op outstanding
// Notes:   answers after 1 or 5 cycles in turn, data inverted outside done
`timescale 1ns/1ps
`default_nettype none
module fcdu_flash_model #(
  parameter int FL_WIDTH = 128
) (
  input wire logic                 CLK,
  input wire logic                 FL_START,
  input wire logic [15:0]          FL_ADDR,
  output logic                     FL_DONE,
  output logic     [FL_WIDTH-1:0]  FL_RDATA
);
  logic [15:0] addr;
  int          cnt;
  logic        slow;
  function automatic logic [FL_WIDTH-1:0] line(input logic [15:0] a);
    for (int k = 0; k < FL_WIDTH / 32; k++) line[32*k+:32] = {8'ha5, a, 8'(k)};
  endfunction
  initial begin
    FL_DONE = 1'b0;
    FL_RDATA = '0;
    cnt = 0;
    slow = 1'b0;
    addr = '0;
  end
  always @(posedge CLK) begin
    FL_DONE <= 1'b0;
    FL_RDATA <= ~line(addr);
    if (FL_START) begin
      addr <= FL_ADDR;
      cnt <= slow ? 5 : 1;
      slow <= !slow;
    end else if (cnt == 1) begin
      FL_DONE <= 1'b1;
      FL_RDATA <= line(addr);
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Purpose: register level test of fcdu_top
// Assumes: CE tied high
// Notes:   one access per two cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fcdu_pkg::*;
  localparam int          FB  = 32'h0008_0000;
  localparam int          NL  = 128;
  localparam logic [31:0] CAL = 32'h0000_0c3a;
  localparam logic [7:0]  RES = FCDU_RES_OFS;
  logic CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, FETCH_REQ = 0;
  logic FL_START, FL_DONE, FLASH_IRQ, FETCH_VALID;
  logic [7:0] REG_ADDR = 0;
  logic [31:0] REG_WDATA = 0, REG_RDATA, FETCH_DATA, d;
  logic [19:0] FETCH_ADDR = 0;
  logic [1:0] GP_BITS;
  logic [15:0] FL_ADDR;
  logic [127:0] FL_RDATA;
  fcdu_op_e FL_OP;
  int fails = 0, tests_run = 0, starts = 0, n;
  logic [7:0] ops [6] = '{FCDU_EA, FCDU_EPL, FCDU_ES, FCDU_EPA, FCDU_WP, FCDU_EWP};
  int nst [6] = '{1, 1, 1, 1, 1, 2};
  fcdu_top #(.CAL_WORD(CAL)) i_dut (.CLK(CLK), .RST_N(RST_N), .CE(1'b1),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .FLASH_IRQ(FLASH_IRQ), .GP_BITS(GP_BITS),
    .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR), .FETCH_VALID(FETCH_VALID),
    .FETCH_DATA(FETCH_DATA), .FL_START(FL_START), .FL_OP(FL_OP), .FL_ADDR(FL_ADDR),
    .FL_DONE(FL_DONE), .FL_RDATA(FL_RDATA));
  fcdu_flash_model i_flash (.CLK(CLK), .FL_START(FL_START), .FL_ADDR(FL_ADDR),
    .FL_DONE(FL_DONE), .FL_RDATA(FL_RDATA));
  always #2 CLK = ~CLK;
  always @(posedge CLK) if (FL_START) starts++;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLK);
    #1;
    REG_ADDR = a;
    REG_WDATA = wd;
    REG_WR = w;
    REG_RD = !w;
    @(posedge CLK);
    #1;
    REG_WR = 0;
    REG_RD = 0;
    d = REG_RDATA;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    acc(0, a, 0);
    chk(d, exp);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] arg, input logic [2:0] st);
    acc(1, FCDU_CMD_OFS, {8'h5a, arg, c});
    for (int i = 0; i < 60; i++) begin
      acc(0, FCDU_STAT_OFS, 0);
      if (d[0] === 1'b1) break;
    end
    if (d[0] !== 1'b1) begin
      fails++;
      give_verdict();
    end
    chk({29'h0, d[2:0]}, {29'h0, st});
  endtask
  task automatic fetch(input logic [19:0] a, input logic [31:0] exp);
    @(posedge CLK);
    #1;
    FETCH_ADDR = a;
    FETCH_REQ = 1;
    @(posedge CLK);
    #1;
    FETCH_REQ = 0;
    repeat (40) begin
      if (FETCH_VALID === 1'b1) break;
      @(posedge CLK);
      #1;
    end
    if (FETCH_VALID !== 1'b1) begin
      fails++;
      give_verdict();
    end
    chk(FETCH_DATA, exp);
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    #1 RST_N = 1;
    repeat (6) @(posedge CLK);
    rdchk(FCDU_STAT_OFS, 32'h1);
    cmd(FCDU_GET_DESCRIPTOR_CMD, 16'h0, 3'b001);
    rdchk(RES, 32'h1);
    rdchk(RES, FB);
    rdchk(RES, 32'd512);
    rdchk(RES, 32'd1);
    rdchk(RES, FB);
    rdchk(RES, NL);
    for (int i = 0; i < NL; i++) rdchk(RES, FB / NL);
    rdchk(RES, 32'h0);
    rdchk(RES, 32'h0);
    acc(1, FCDU_CMD_OFS, {8'h00, 16'h0, FCDU_GET_DESCRIPTOR_CMD});
    rdchk(FCDU_STAT_OFS, 32'h3);
    rdchk(RES, 32'h0);
    foreach (ops[i]) begin
      n = starts;
      cmd(ops[i], 16'h0, 3'b001);
      chk(starts - n, nst[i]);
    end
    cmd(FCDU_SLB, 16'h0, 3'b001);
    n = starts;
    cmd(FCDU_WP, 16'h0, 3'b101);
    chk(starts - n, 0);
    cmd(FCDU_GLB, 16'h0, 3'b001);
    rdchk(RES, 32'h1);
    cmd(FCDU_CLB, 16'h0, 3'b001);
    cmd(FCDU_WP, 16'h0, 3'b001);
    cmd(FCDU_SGP, 16'h1, 3'b001);
    chk({30'h0, GP_BITS}, 32'h2);
    cmd(FCDU_GGP, 16'h0, 3'b001);
    rdchk(RES, 32'h2);
    cmd(FCDU_CGP, 16'h1, 3'b001);
    chk({30'h0, GP_BITS}, 32'h0);
    cmd(FCDU_GCAL, 16'h0, 3'b001);
    rdchk(RES, CAL);
    fetch(20'h00014, 32'ha500_0101);
    chk({16'h0, FL_ADDR}, 32'h1);
    n = starts;
    fetch(20'h00018, 32'ha500_0102);
    chk(starts - n, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
